/* File: include/dpt_pkg.sv */
/*
 * constants, register map and carriers of the dynamic power-down sequencer.
 * assumes a 25 MHz pclk and one APB master with 32-bit data.
 */
package dpt_pkg;

    // ==========================================================
    // clock and time
    localparam int CLK_MHZ      = 25;
    localparam int HARD_US      = 200;
    localparam int PIN_RST_MIN_US = 25;
    localparam int PIN_RST_MAX_US = 50;
    localparam int HARD_CYC_DEF = HARD_US * CLK_MHZ;
    // least time rounds up, longest time rounds down
    localparam int PIN_RST_MIN_CYC = (PIN_RST_MIN_US * CLK_MHZ * 1000 + 999) / 1000;
    localparam int PIN_RST_MAX_CYC = (PIN_RST_MAX_US * CLK_MHZ * 1000) / 1000;

    // ==========================================================
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_WIN_START = 8'h32;
    localparam logic [7:0] IDX_WIN_END   = 8'h33;
    localparam logic [7:0] IDX_PERIOD    = 8'h40;
    localparam logic [7:0] IDX_CTRL      = 8'h41;
    localparam logic [7:0] IDX_STATUS    = 8'h42;

    // ==========================================================
    // reset values and bit positions
    localparam logic [15:0] RST_WIN_START = 16'hFFFF;
    localparam logic [15:0] RST_WIN_END   = 16'h0000;
    localparam logic [15:0] RST_PERIOD    = 16'hFFFF;
    localparam int          CTRL_SWRST_BIT = 31;
    localparam int          AMP_BLOCK      = 3;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [20:0] rsvd;
        logic [3:0]  clk_div;
        logic        input_short_en;
        logic        front_end_sleep_bit;
        logic [4:0]  dyn_select;
    } dpt_ctrl_s;

    localparam dpt_ctrl_s RST_CTRL = '{default: 1'b0};

    typedef struct packed {
        logic       hard_sleep_mode;
        logic       front_end_sleep;
        logic [4:0] block_sleep;
        logic       input_short;
    } dpt_sleep_s;

    typedef enum logic [2:0] {
        PIN_HIGH  = 3'b001,
        PIN_LOW   = 3'b010,
        PIN_HARD  = 3'b100
    } dpt_pin_e;

endpackage

/* File: verilog/dpt_sync.sv */
/*
 * two-flop synchroniser for one level coming from a pin.
 * assumes the input is asynchronous to clk; output is the second flop.
 */
`timescale 1ns/1ps
`default_nettype none

module dpt_sync
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output var  logic sync_out
);

    logic meta;

    // idle level of a reset pin is high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta     <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/dpt_top.sv */
/*
 * dynamic power-down sequencer: period counter, power-down window, pin and
 * register sleep modes, APB register slave.
 * assumes pclk at 25 MHz and an asynchronous reset pin from outside.
 */
`timescale 1ns/1ps
`default_nettype none

module dpt_top
    import dpt_pkg::*;
#(
    parameter int HARD_CYC = HARD_CYC_DEF
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        reset_n_pin,
    output var  dpt_sleep_s  sleep_out,
    output var  logic        dyn_sleep_signal,
    output var  logic        sequencer_clock
);

    logic [15:0] powerdown_window_start;
    logic [15:0] powerdown_window_end;
    logic [15:0] period_terminal_count;
    dpt_ctrl_s   ctrl;
    logic [15:0] period_cnt;
    logic [3:0]  div_cnt;
    logic        pin_sync;
    logic [15:0] low_cnt;
    dpt_pin_e    pin_state;
    logic        pin_reg_reset;
    logic        soft_reset;
    logic        apb_wr;
    logic        mapped;
    logic [7:0]  idx;
    dpt_sleep_s  next_sleep;

    function automatic logic in_window(input logic [15:0] cnt,
                                       input logic [15:0] st,
                                       input logic [15:0] en);
        in_window = (cnt >= st) && (cnt <= en);
    endfunction

    // ==========================================================
    // APB slave, zero wait states
    assign idx    = paddr[9:2];
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    always_comb
    begin
        mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                 (idx == IDX_WIN_START || idx == IDX_WIN_END || idx == IDX_PERIOD ||
                  idx == IDX_CTRL || idx == IDX_STATUS);
        pslverr = psel && penable && !mapped;
    end

    // software reset
    // bit 31 of a control write is a self-clearing reset of all registers
    assign soft_reset = (apb_wr && idx == IDX_CTRL && paddr[1:0] == 2'h0 &&
                         paddr[11:10] == 2'h0 && pwdata[CTRL_SWRST_BIT]) || pin_reg_reset;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            powerdown_window_start <= RST_WIN_START;
            powerdown_window_end   <= RST_WIN_END;
            period_terminal_count  <= RST_PERIOD;
            ctrl                   <= RST_CTRL;
        end
        else if (soft_reset)
        begin
            powerdown_window_start <= RST_WIN_START;
            powerdown_window_end   <= RST_WIN_END;
            period_terminal_count  <= RST_PERIOD;
            ctrl                   <= RST_CTRL;
        end
        else if (apb_wr && mapped)
        begin
            if (idx == IDX_WIN_START)
                powerdown_window_start <= pwdata[15:0];
            if (idx == IDX_WIN_END)
                powerdown_window_end <= pwdata[15:0];
            if (idx == IDX_PERIOD)
                period_terminal_count <= pwdata[15:0];
            if (idx == IDX_CTRL)
            begin
                ctrl      <= dpt_ctrl_s'(pwdata);
                ctrl.rsvd <= '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (idx)
                IDX_WIN_START: prdata <= {16'h0000, powerdown_window_start};
                IDX_WIN_END:   prdata <= {16'h0000, powerdown_window_end};
                IDX_PERIOD:    prdata <= {16'h0000, period_terminal_count};
                IDX_CTRL:      prdata <= ctrl;
                IDX_STATUS:    prdata <= {14'h0000, sleep_out.hard_sleep_mode,
                                          dyn_sleep_signal, period_cnt};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // sequencer clock enable
    // divide by clk_div + 1
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= 4'h0;
        else if (div_cnt >= ctrl.clk_div)
            div_cnt <= 4'h0;
        else
            div_cnt <= div_cnt + 4'h1;
    end
    assign sequencer_clock = (div_cnt >= ctrl.clk_div);

    // 16-bit count; >= guards a terminal lowered below the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            period_cnt <= 16'h0000;
        else if (soft_reset)
            period_cnt <= 16'h0000;
        else if (sequencer_clock)
            period_cnt <= (period_cnt >= period_terminal_count) ? 16'h0000 : period_cnt + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dyn_sleep_signal <= 1'b0;
        else
            dyn_sleep_signal <= in_window(period_cnt, powerdown_window_start, powerdown_window_end);
    end

    // ==========================================================
    // reset pin: pulse width measurement
    dpt_sync u_sync
    (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (reset_n_pin),
        .sync_out (pin_sync)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_cnt <= 16'h0000;
        else if (pin_sync)
            low_cnt <= 16'h0000;
        else if (low_cnt < 16'(HARD_CYC))
            low_cnt <= low_cnt + 16'h0001;
    end

    // hard sleep after a long low
    // low pulse of 25 to 50 us resets registers on release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_state     <= PIN_HIGH;
            pin_reg_reset <= 1'b0;
        end
        else
        begin
            pin_reg_reset <= 1'b0;
            unique case (pin_state)
                PIN_HIGH:
                    if (!pin_sync)
                        pin_state <= PIN_LOW;
                PIN_LOW:
                    if (pin_sync)
                    begin
                        pin_state     <= PIN_HIGH;
                        pin_reg_reset <= (low_cnt >= 16'(PIN_RST_MIN_CYC)) &&
                                         (low_cnt <= 16'(PIN_RST_MAX_CYC));
                    end
                    else if (low_cnt >= 16'(HARD_CYC))
                        pin_state <= PIN_HARD;
                PIN_HARD:
                    if (pin_sync)
                        pin_state <= PIN_HIGH;
                default:
                    pin_state <= PIN_HIGH;
            endcase
        end
    end

    // ==========================================================
    // sleep outputs
    always_comb
    begin
        next_sleep.hard_sleep_mode = (pin_state == PIN_HARD);
        next_sleep.front_end_sleep = ctrl.front_end_sleep_bit || next_sleep.hard_sleep_mode;
        next_sleep.block_sleep     = ctrl.dyn_select & {5{dyn_sleep_signal}};
        next_sleep.input_short     = ctrl.input_short_en &&
                                     (next_sleep.block_sleep[AMP_BLOCK] || next_sleep.front_end_sleep);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_out <= '0;
        else
            sleep_out <= next_sleep;
    end

    // ==========================================================
    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // misaligned aliases decode to the same index but must not store
    win_start_reg_a: assert property (apb_wr && mapped && idx == IDX_WIN_START && !soft_reset |=>
        powerdown_window_start == $past(pwdata[15:0])) else $error("window start not stored");
    win_inclusive_a: assert property (##1 dyn_sleep_signal ==
        $past(in_window(period_cnt, powerdown_window_start, powerdown_window_end)))
        else $error("window edge wrong");
    period_wrap_a: assert property (sequencer_clock && !soft_reset &&
        period_cnt == period_terminal_count |=> period_cnt == 16'h0000)
        else $error("period did not wrap");
    hard_sleep_a: assert property (pin_state == PIN_LOW && !pin_sync &&
        low_cnt >= 16'(HARD_CYC) |=> ##1 sleep_out.hard_sleep_mode) else $error("no hard sleep");
    afe_sleep_a: assert property (ctrl.front_end_sleep_bit |=> sleep_out.front_end_sleep)
        else $error("front end not asleep");
    block_select_a: assert property (##1 sleep_out.block_sleep ==
        ($past(ctrl.dyn_select) & {5{$past(dyn_sleep_signal)}})) else $error("block sleep wrong");
    input_short_a: assert property (ctrl.input_short_en && dyn_sleep_signal &&
        ctrl.dyn_select[AMP_BLOCK] |=> sleep_out.input_short) else $error("inputs not shorted");
    pin_reset_a: assert property (pin_reg_reset |=> period_terminal_count == RST_PERIOD &&
        powerdown_window_start == RST_WIN_START && ctrl == RST_CTRL) else $error("pin pulse did not reset");
    // a control write or reset in the two cycles would legally move the divider
    div_rate_a: assert property (sequencer_clock && ctrl.clk_div == 4'h1 && $stable(ctrl.clk_div) &&
        !(apb_wr && idx == IDX_CTRL) && !soft_reset ##1 !(apb_wr && idx == IDX_CTRL) && !soft_reset
        |-> !sequencer_clock ##1 sequencer_clock) else $error("divider rate wrong");
    out_window_a: assert property (!dyn_sleep_signal |=> sleep_out.block_sleep == 5'h00)
        else $error("block slept outside window");

endmodule

`default_nettype wire

/* File: verif/dpt_pin_host.sv */
/*
 * host side of the reset pin: drives timed low pulses on it.
 * assumes pclk is the bench clock and the pin idles high.
 */
`timescale 1ns/1ps
`default_nettype none

module dpt_pin_host
(
    input  wire logic pclk,
    output var  logic reset_n_pin
);
    initial reset_n_pin = 1'b1;

    // ==========================================================
    // pin pulses, called just after a rising edge
    task automatic hold_low(input int n);
        reset_n_pin <= 1'b0;
        repeat (n) @(posedge pclk);
        reset_n_pin <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: verif/dynamic_powerdown_timing_test.sv */
/*
 * self-checking bench of the dynamic power-down sequencer.
 * assumes dpt_top and the pin host model; APB master lives here.
 */
`timescale 1ns/1ps
`default_nettype none

module dynamic_powerdown_timing_test
    import dpt_pkg::*;
;
    localparam int HC = 2000;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        reset_n_pin, dyn_sleep_signal, sequencer_clock, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    dpt_sleep_s  sleep_out;
    int          num_errors, n_tests, cyc;

    dpt_top #(.HARD_CYC(HC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_n_pin(reset_n_pin), .sleep_out(sleep_out),
        .dyn_sleep_signal(dyn_sleep_signal), .sequencer_clock(sequencer_clock));
    dpt_pin_host host (.pclk(pclk), .reset_n_pin(reset_n_pin));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ==========================================================
    // hang guard, well above the longest expected run
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // APB transfer: setup, then access until pready at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function automatic int exp_cnt(int s, int e, int k);
        return (s <= e) ? k * (e - s + 1) : 0;
    endfunction

    // ==========================================================
    // one window setup, observed over two whole periods
    task automatic run_win(input int p, input int s, input int e, input int d,
                           input logic [4:0] sel, input logic sh);
        int   per, cnt, cp;
        logic pd;
        per = (p + 1) * (d + 1);
        cnt = 0;
        cp  = 0;
        apb(1'b1, 12'h100, p);
        apb(1'b1, 12'hC8, s);
        apb(1'b1, 12'hCC, e);
        apb(1'b1, 12'h104, {21'h0, d[3:0], sh, 1'b0, sel});
        repeat (per + 2) @(posedge pclk);
        #1 pd = dyn_sleep_signal;
        repeat (2 * per)
        begin
            @(posedge pclk);
            #1;
            cnt += dyn_sleep_signal;
            cp  += sequencer_clock;
            chk(sleep_out.block_sleep, pd ? sel : 5'h00);
            chk(sleep_out.input_short, sh & pd & sel[3]);
            pd = dyn_sleep_signal;
        end
        chk(cnt, exp_cnt(s, e, 2 * (d + 1)));
        chk(cp, 2 * (p + 1));
    endtask

    initial
    begin
        int p, s, e, d;
        logic [4:0] sel;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        num_errors = 0;
        n_tests    = 0;
        cyc        = 0;
        void'($urandom(95));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'hC8, 32'h0000FFFF);
        rdc(12'hCC, 32'h00000000);
        rdc(12'h100, 32'h0000FFFF);
        rdc(12'h104, 32'h00000000);
        apb(1'b0, 12'h10C, 32'h0);
        chk(rd, 32'h00000000);
        chk(er, 1'b1);
        apb(1'b1, 12'hC9, 32'h5);
        chk(er, 1'b1);
        rdc(12'hC8, 32'h0000FFFF);
        // corner windows first: full, single last count, empty
        for (int t = 0; t < 6; t++)
        begin
            p   = 20 + $urandom % 41;
            d   = (t == 1) ? 15 : (t == 2) ? 1 : $urandom % 4;
            s   = $urandom % (p + 1);
            e   = s + $urandom % (p + 1 - s);
            sel = $urandom;
            if (t == 0) {s, e} = {32'd0, p};
            if (t == 1) {s, e} = {p, p};
            if (t == 2) {s, e} = {e + 1, e};
            // pair input short with amp select for the corner windows, random after
            run_win(p, s, e, d, sel, (t < 3) ? sel[3] : 1'($urandom));
        end
        apb(1'b1, 12'h104, 32'h00000020);
        repeat (3) @(posedge pclk);
        #1 chk(sleep_out.front_end_sleep, 1'b1);
        apb(1'b1, 12'hC8, 32'h1234);
        apb(1'b1, 12'h104, 32'h80000000);
        rdc(12'hC8, 32'h0000FFFF);
        apb(1'b1, 12'hC8, 32'h1234);
        host.hold_low(100);
        repeat (10) @(posedge pclk);
        rdc(12'hC8, 32'h00001234);
        host.hold_low(750);
        repeat (10) @(posedge pclk);
        rdc(12'hC8, 32'h0000FFFF);
        fork
            host.hold_low(HC + 20);
            begin
                repeat (HC + 10) @(posedge pclk);
                #1 chk(sleep_out.hard_sleep_mode, 1'b1);
                // status shows hard sleep set and the empty window inactive
                apb(1'b0, 12'h108, 32'h0);
                chk(rd[31:16], 32'h00000002);
            end
        join
        repeat (6) @(posedge pclk);
        #1 chk(sleep_out.hard_sleep_mode, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
